// file: bench/fpq_flash_model.sv
// Behavioural parallel NOR flash: protection, unlock, query and autoselect
`timescale 1ns/10ps
module fpq_flash_model
  import fpq_pkg::*;
#(
  parameter logic [17:0]  PROT_INIT = 18'h0_0000,
  parameter logic [183:0] QTAB      = '0
)(
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [21:0] addr,
  input  wire logic [7:0]  din,
  output logic      [7:0]  dout,
  input  wire logic        reset_n,
  input  wire logic        reset_hv,
  input  wire logic        supply_ok
);
  logic [7:0]  mem [256];
  logic [17:0] prot = PROT_INIT;
  logic [1:0]  mode = 2'd0;
  logic [1:0]  step = 2'd0;
  logic        armed = 1'b0;
  logic [7:0]  rdv;
  logic [7:0]  qi;
  logic [5:0]  sa;
  logic [4:0]  blk;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
  assign sa = addr[21:16];
  assign blk = sa == 6'd0 ? 5'd0 : sa == 6'd63 ? 5'd17 : sa >= 6'd60 ? 5'd16 :
               5'(sa[5:2]) + 5'd1;
  // Also follows array writes, so a read at the address just programmed sees new data
  always_comb begin
    qi = addr[7:0] - 8'h10;
    if (mode == 2'd2) rdv = addr[15:0] == A_PROT_OFS ? {7'd0, prot[blk]} : 8'h00;
    else if (mode[0]) rdv = qi < 8'd23 ? QTAB[183 - 8 * int'(qi) -: 8] : 8'h00;
    else rdv = mem[addr[7:0]];
  end
  // Released bus shows the inverse so stale data never looks valid
  assign dout = (!ce_n && !oe_n) ? rdv : ~rdv;
  always @(negedge we_n) armed = supply_ok && reset_n && !ce_n && oe_n;
  always @(negedge reset_n or negedge supply_ok) begin
    mode = 2'd0;
    step = 2'd0;
    armed = 1'b0;
  end
  always @(posedge we_n) begin
    if (armed && supply_ok && !ce_n && oe_n) begin
      if (din == D_RESET) begin
        mode = mode == 2'd3 ? 2'd2 : 2'd0;
        step = 2'd0;
      end else if (din == D_QUERY && addr[7:0] == 8'h55 && !mode[0]) begin
        mode = mode + 2'd1;
      end else if (step == 2'd3) begin
        if (!prot[blk] || reset_hv) mem[addr[7:0]] = din;
        step = 2'd0;
      end else if (step == 2'd0 && din == D_UNLOCK1 && addr == A_UNLOCK1) step = 2'd1;
      else if (step == 2'd1 && din == D_UNLOCK2 && addr == A_UNLOCK2) step = 2'd2;
      else if (step == 2'd2 && din == D_PROG) step = 2'd3;
      else begin
        // Autoselect by command only; the address_line_nine path is left to programmers
        mode = (step == 2'd2 && din == D_AUTOSEL) ? 2'd2 : mode;
        step = 2'd0;
      end
    end
    armed = 1'b0;
  end
endmodule // fpq_flash_model

// file: bench/fpq_host_chk.sv
// Concurrent checks on the host controller ports
`timescale 1ns/10ps
module fpq_host_chk
  import fpq_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        supply_ok,
  input wire logic        hv_request,
  input wire logic        cmd_valid,
  input wire logic [2:0]  cmd_op,
  input wire logic        cmd_ready,
  input wire logic [17:0] blk_protected,
  input wire logic [17:0] blk_checked,
  input wire logic        unprotect_ready,
  input wire logic        fl_ce_n,
  input wire logic        fl_oe_n,
  input wire logic        fl_we_n,
  input wire logic [21:0] fl_addr,
  input wire logic [7:0]  fl_dq_o,
  input wire logic        fl_dq_oe,
  input wire logic        fl_reset_n,
  input wire logic        fl_reset_hv
);
  logic [7:0] up_q;
  logic [7:0] up_d;
  logic       take;
  assign take = cmd_valid && cmd_ready;
  // Cycles of good supply since reset or the last lockout
  always_comb up_d = !supply_ok ? 8'd0 : (up_q == 8'hFF ? up_q : up_q + 8'd1);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) up_q <= 8'd0;
    else up_q <= up_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  chk_write_pins: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe)
    else $error("write strobe without select or with output enable");
  chk_no_fight: assert property (!fl_oe_n |-> fl_we_n && !fl_dq_oe)
    else $error("read overlaps a write");
  chk_low_supply: assert property (!supply_ok |-> ##[1:2] (fl_we_n && !fl_reset_n))
    else $error("activity under low supply");
  chk_pwrup_guard: assert property (cmd_ready |-> up_q >= PWRUP_CYC)
    else $error("ready before power-up guard");
  chk_query_start: assert property (take && cmd_op == OP_QUERY |->
    ##[2:4] (!fl_we_n && fl_addr == A_QUERY && fl_dq_o == D_QUERY))
    else $error("query entry write wrong");
  chk_prog_unlock: assert property (take && cmd_op == OP_PROG |->
    ##[2:4] (!fl_we_n && fl_addr == A_UNLOCK1 && fl_dq_o == D_UNLOCK1))
    else $error("program without unlock");
  chk_hv_idle: assert property ($rose(fl_reset_hv) |-> $past(hv_request) && fl_reset_n)
    else $error("high voltage without request");
  chk_unprot_pre: assert property (unprotect_ready |-> &blk_checked && &blk_protected)
    else $error("unprotect ready too early");
  cover property (take && cmd_op == OP_PCHK);
  cover property (fl_reset_hv && !fl_we_n);
  cover property ($fell(supply_ok) && !cmd_ready);
endmodule // fpq_host_chk

bind fpq_host fpq_host_chk u_chk (.clk, .reset, .supply_ok, .hv_request, .cmd_valid, .cmd_op,
  .cmd_ready, .blk_protected, .blk_checked, .unprotect_ready, .fl_ce_n, .fl_oe_n, .fl_we_n,
  .fl_addr, .fl_dq_o, .fl_dq_oe, .fl_reset_n, .fl_reset_hv);

// file: bench/tb_fpq_host.sv
// Testbench for the flash protect and query host controller
`timescale 1ns/10ps
module tb_fpq_host
  import fpq_pkg::*;
();
  localparam logic [17:0]  PROT = 18'h2_0001;
  localparam logic [183:0] QTAB = 184'h51_5259_0200_4000_0000_0000_2736_0000_0400_0A00_0500_0400;
  typedef struct packed {
    logic [2:0]  op;
    logic [21:0] a;
    logic [7:0]  d;
    logic [7:0]  x;
    logic        c;
  } fpq_row_t;
  logic        clk, reset, supply_ok, hv_request, cmd_valid, cmd_ready, done, lockout_abort;
  logic        query_ok, unprotect_ready, fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe, fl_reset_n;
  logic        fl_reset_hv;
  logic [2:0]  cmd_op;
  logic [21:0] cmd_addr, fl_addr;
  logic [7:0]  cmd_data, rd_data, vcc_min, vcc_max, query_rdata, fl_dq_o, fl_dq_i;
  logic [15:0] ext_table_addr;
  logic [17:0] blk_protected, blk_checked;
  logic [4:0]  query_raddr;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cyc = 0;
  fpq_row_t    rows [15] = '{
    '{OP_READ, 22'h00_0005, 8'h00, 8'hFF, 1'b1}, '{OP_PROG, 22'h00_0010, 8'h5A, 8'h00, 1'b0},
    '{OP_READ, 22'h00_0010, 8'h00, 8'hFF, 1'b1}, '{OP_PROG, 22'h10_0020, 8'hA5, 8'h00, 1'b0},
    '{OP_READ, 22'h10_0020, 8'h00, 8'hA5, 1'b1}, '{OP_PCHK, 22'h00_0000, 8'h00, 8'h01, 1'b1},
    '{OP_PCHK, 22'h03_0000, 8'h00, 8'h00, 1'b1}, '{OP_PCHK, 22'h3B_0000, 8'h00, 8'h00, 1'b1},
    '{OP_PCHK, 22'h3C_0000, 8'h00, 8'h00, 1'b1}, '{OP_PCHK, 22'h3F_0000, 8'h00, 8'h01, 1'b1},
    '{OP_PCHK, 22'h04_0000, 8'h00, 8'h00, 1'b1}, '{OP_QUERY, 22'h00_0000, 8'h00, 8'h00, 1'b1},
    '{OP_RESET, 22'h3F_1234, 8'h00, 8'h00, 1'b0}, '{3'h5, 22'h00_0000, 8'h00, 8'h00, 1'b0},
    '{OP_READ, 22'h10_0020, 8'h00, 8'hA5, 1'b1}};
  fpq_host DUT (.clk, .reset, .supply_ok, .hv_request, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data,
    .cmd_ready, .done, .lockout_abort, .rd_data, .query_ok, .ext_table_addr, .vcc_min, .vcc_max,
    .blk_protected, .blk_checked, .unprotect_ready, .query_raddr, .query_rdata, .fl_ce_n,
    .fl_oe_n, .fl_we_n, .fl_addr, .fl_dq_o, .fl_dq_oe, .fl_dq_i, .fl_reset_n, .fl_reset_hv);
  fpq_flash_model #(.PROT_INIT(PROT), .QTAB(QTAB)) u_flash (.ce_n(fl_ce_n), .oe_n(fl_oe_n),
    .we_n(fl_we_n), .addr(fl_addr), .din(fl_dq_o), .dout(fl_dq_i), .reset_n(fl_reset_n),
    .reset_hv(fl_reset_hv), .supply_ok);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic go(input logic [2:0] o, input logic [21:0] a, input logic [7:0] d);
    while (cmd_ready !== 1'b1) @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    cmd_addr <= a;
    cmd_data <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask
  task automatic op(input logic [2:0] o, input logic [21:0] a, input logic [7:0] d);
    int n;
    go(o, a, d);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 400);
    chk(done, 1'b1);
  endtask
  initial begin
    int n;
    reset = 1'b1;
    supply_ok = 1'b1;
    hv_request = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_READ;
    cmd_addr = 22'h00_0000;
    cmd_data = 8'h00;
    query_raddr = 5'h00;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      op(rows[i].op, rows[i].a, rows[i].d);
      if (rows[i].c) begin
        chk(rd_data, rows[i].x);
      end
    end
    chk(blk_checked, 18'h3_8007);
    chk(blk_protected, PROT);
    chk(unprotect_ready, 1'b0);
    chk(query_ok, 1'b1);
    chk({ext_table_addr, vcc_min, vcc_max}, 32'h0040_2736);
    for (int i = 0; i < 23; i++) begin
      query_raddr <= 5'(i);
      repeat (2) @(posedge clk);
      chk(query_rdata, QTAB[183 - 8 * i -: 8]);
    end
    $display("test table done");
    hv_request <= 1'b1;
    repeat (4) @(posedge clk);
    chk(fl_reset_hv, 1'b1);
    op(OP_PROG, 22'h00_0011, 8'h7E);
    repeat (2) @(posedge clk);
    hv_request <= 1'b0;
    repeat (4) @(posedge clk);
    chk(fl_reset_hv, 1'b0);
    op(OP_READ, 22'h00_0011, 8'h00);
    chk(rd_data, 8'h7E);
    op(OP_PROG, 22'h3F_0013, 8'hC3);
    op(OP_READ, 22'h3F_0013, 8'h00);
    chk(rd_data, 8'hFF);
    $display("test temporary unprotect done");
    go(OP_PROG, 22'h10_0030, 8'h66);
    repeat (3) @(posedge clk);
    supply_ok <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (lockout_abort !== 1'b1 && n < 50);
    chk(lockout_abort, 1'b1);
    repeat (10) @(posedge clk);
    supply_ok <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 200);
    chk(n >= int'(PWRUP_CYC), 1'b1);
    op(OP_READ, 22'h10_0030, 8'h00);
    chk(rd_data, 8'hFF);
    $display("test supply lockout done");
    go(OP_QUERY, 22'h00_0000, 8'h00);
    repeat (12) @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    chk({fl_ce_n, fl_we_n, fl_reset_n, cmd_ready}, 4'b1100);
    reset <= 1'b0;
    op(OP_READ, 22'h00_0005, 8'h00);
    chk(rd_data, 8'hFF);
    $display("test mid-run reset done");
    conclude();
  end
endmodule // tb_fpq_host

// file: rtl/fpq_host.sv
// Host controller driving a parallel NOR flash: query, protect check, program, temp unprotect
// Function
// - Protect methods use high voltage on reset pin with ordinary bus cycles.
// - Host protects no blocks; unprotect_ready only flags every block checked and protected, and does not gate hv_request.
// - Alternate method needs high voltage on address line nine; programmers only.
// - Write needs chip select and write strobe low, output enable high.
// - Writing 98h to 55h from read-array enters query mode.
// - Query mode ends with the reset command or a hardware reset, back to read-array.
`timescale 1ns/10ps
module fpq_host
  import fpq_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        supply_ok,
  input  wire logic        hv_request,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_op,
  input  wire logic [21:0] cmd_addr,
  input  wire logic [7:0]  cmd_data,
  output logic             cmd_ready,
  output logic             done,
  output logic             lockout_abort,
  output logic [7:0]       rd_data,
  output logic             query_ok,
  output logic [15:0]      ext_table_addr,
  output logic [7:0]       vcc_min,
  output logic [7:0]       vcc_max,
  output logic [17:0]      blk_protected,
  output logic [17:0]      blk_checked,
  output logic             unprotect_ready,
  input  wire logic [4:0]  query_raddr,
  output logic [7:0]       query_rdata,
  output logic             fl_ce_n,
  output logic             fl_oe_n,
  output logic             fl_we_n,
  output logic [21:0]      fl_addr,
  output logic [7:0]       fl_dq_o,
  output logic             fl_dq_oe,
  input  wire logic [7:0]  fl_dq_i,
  output logic             fl_reset_n,
  output logic             fl_reset_hv
);
  fpq_cycle_t  cy_q, cy_d;
  logic        busy_q, busy_d;
  logic [2:0]  op_q, op_d;
  logic [4:0]  idx_q, idx_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [7:0]  pwr_q, pwr_d;
  logic [21:0] ua_q, ua_d;
  logic [7:0]  ud_q, ud_d;
  logic        ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
  logic [21:0] fa_q, fa_d;
  logic [7:0]  fdo_q, fdo_d;
  logic        foe_q, foe_d, rst_n_q, rst_n_d, hv_q, hv_d;
  logic        rdy_q, rdy_d, done_q, done_d, abort_q, abort_d;
  logic [7:0]  rd_q, rd_d;
  logic        qok_q, qok_d;
  logic [15:0] ext_q, ext_d;
  logic [7:0]  vmin_q, vmin_d, vmax_q, vmax_d;
  logic [17:0] prot_q, prot_d, chk_q, chk_d;
  logic        upr_q, upr_d;
  logic        mem_we;
  logic [4:0]  mem_wa;
  fpq_step_t   st;
  logic [5:0]  qa;
  logic [4:0]  blk;

  fpq_qmem u_qmem (
    .clk   (clk),
    .we    (mem_we),
    .waddr (mem_wa),
    .wdata (fl_dq_i),
    .raddr (query_raddr),
    .rdata (query_rdata)
  );

  always_comb begin
    st      = fpq_step(op_q, idx_q, ua_q, ud_q);
    qa      = st.a[5:0];
    blk     = fpq_block(ua_q[21:16]);
    cy_d    = cy_q;
    busy_d  = busy_q;
    op_d    = op_q;
    idx_d   = idx_q;
    cnt_d   = cnt_q;
    pwr_d   = pwr_q;
    ua_d    = ua_q;
    ud_d    = ud_q;
    ce_n_d  = ce_n_q;
    oe_n_d  = oe_n_q;
    we_n_d  = we_n_q;
    fa_d    = fa_q;
    fdo_d   = fdo_q;
    foe_d   = foe_q;
    rst_n_d = 1'b1;
    hv_d    = hv_q;
    rdy_d   = 1'b0;
    done_d  = 1'b0;
    abort_d = 1'b0;
    rd_d    = rd_q;
    qok_d   = qok_q;
    ext_d   = ext_q;
    vmin_d  = vmin_q;
    vmax_d  = vmax_q;
    prot_d  = prot_q;
    chk_d   = chk_q;
    mem_we  = 1'b0;
    mem_wa  = idx_q - 5'd1;
    if (!supply_ok) begin
      // Below lockout: stop, park all strobes high, hold the chip in reset
      abort_d = busy_q;
      busy_d  = 1'b0;
      cy_d    = FPQ_CY_IDLE;
      ce_n_d  = 1'b1;
      oe_n_d  = 1'b1;
      we_n_d  = 1'b1;
      foe_d   = 1'b0;
      rst_n_d = 1'b0;
      hv_d    = 1'b0;
      pwr_d   = PWRUP_CYC;
    end else if (pwr_q != 8'd0) begin
      // Power-up guard keeps the write strobe high while the supply settles
      pwr_d = pwr_q - 8'd1;
    end else begin
      case (cy_q)
        FPQ_CY_IDLE: begin
          if (!busy_q) begin
            hv_d  = hv_request;
            rdy_d = 1'b1;
            if (cmd_valid && rdy_q) begin
              busy_d = 1'b1;
              rdy_d  = 1'b0;
              op_d   = (cmd_op > OP_RESET) ? OP_RESET : cmd_op;
              idx_d  = 5'd0;
              ua_d   = cmd_addr;
              ud_d   = cmd_data;
            end
          end else begin
            cy_d   = FPQ_CY_SETUP;
            ce_n_d = 1'b0;
            fa_d   = st.a;
            fdo_d  = st.d;
            foe_d  = st.wr;
          end
        end
        FPQ_CY_SETUP: begin
          cy_d   = FPQ_CY_STROBE;
          we_n_d = !st.wr;
          oe_n_d = st.wr;
          cnt_d  = st.wr ? WP_CYC : ACC_CYC;
        end
        FPQ_CY_STROBE: begin
          if (cnt_q > 5'd1) begin
            cnt_d = cnt_q - 5'd1;
          end else begin
            cy_d   = FPQ_CY_HOLD;
            we_n_d = 1'b1;
            oe_n_d = 1'b1;
            if (!st.wr) begin
              rd_d = fl_dq_i;
              if (op_q == OP_QUERY) begin
                mem_we = 1'b1;
                case (qa)
                  Q_FIRST:         qok_d = (fl_dq_i == Q_SIG0);
                  Q_FIRST + 6'd1:  qok_d = qok_q && (fl_dq_i == Q_SIG1);
                  Q_FIRST + 6'd2:  qok_d = qok_q && (fl_dq_i == Q_SIG2);
                  Q_EXT_LO:        ext_d[7:0] = fl_dq_i;
                  Q_EXT_HI:        ext_d[15:8] = fl_dq_i;
                  Q_VMIN:          vmin_d = fl_dq_i;
                  Q_VMAX:          vmax_d = fl_dq_i;
                  default:         qok_d = qok_q;
                endcase
              end
              if (op_q == OP_PCHK) begin
                chk_d[blk]  = 1'b1;
                prot_d[blk] = (fl_dq_i == D_PROTECTED);
              end
            end
          end
        end
        FPQ_CY_HOLD: begin
          cy_d   = FPQ_CY_IDLE;
          ce_n_d = 1'b1;
          foe_d  = 1'b0;
          if (idx_q == fpq_last(op_q)) begin
            // Query and autoselect always end with the reset command
            busy_d = 1'b0;
            done_d = 1'b1;
          end else begin
            idx_d = idx_q + 5'd1;
          end
        end
        default: cy_d = FPQ_CY_IDLE;
      endcase
    end
    upr_d = (&chk_q) && (&prot_q);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cy_q    <= FPQ_CY_IDLE;
      busy_q  <= 1'b0;
      op_q    <= OP_READ;
      idx_q   <= 5'd0;
      cnt_q   <= 5'd0;
      pwr_q   <= PWRUP_CYC;
      ua_q    <= 22'h00_0000;
      ud_q    <= 8'h00;
      ce_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      fa_q    <= 22'h00_0000;
      fdo_q   <= 8'h00;
      foe_q   <= 1'b0;
      rst_n_q <= 1'b0;
      hv_q    <= 1'b0;
      rdy_q   <= 1'b0;
      done_q  <= 1'b0;
      abort_q <= 1'b0;
      rd_q    <= 8'h00;
      qok_q   <= 1'b0;
      ext_q   <= 16'h0000;
      vmin_q  <= 8'h00;
      vmax_q  <= 8'h00;
      prot_q  <= 18'h0_0000;
      chk_q   <= 18'h0_0000;
      upr_q   <= 1'b0;
    end else begin
      cy_q    <= cy_d;
      busy_q  <= busy_d;
      op_q    <= op_d;
      idx_q   <= idx_d;
      cnt_q   <= cnt_d;
      pwr_q   <= pwr_d;
      ua_q    <= ua_d;
      ud_q    <= ud_d;
      ce_n_q  <= ce_n_d;
      oe_n_q  <= oe_n_d;
      we_n_q  <= we_n_d;
      fa_q    <= fa_d;
      fdo_q   <= fdo_d;
      foe_q   <= foe_d;
      rst_n_q <= rst_n_d;
      hv_q    <= hv_d;
      rdy_q   <= rdy_d;
      done_q  <= done_d;
      abort_q <= abort_d;
      rd_q    <= rd_d;
      qok_q   <= qok_d;
      ext_q   <= ext_d;
      vmin_q  <= vmin_d;
      vmax_q  <= vmax_d;
      prot_q  <= prot_d;
      chk_q   <= chk_d;
      upr_q   <= upr_d;
    end
  end

  assign cmd_ready       = rdy_q;
  assign done            = done_q;
  assign lockout_abort   = abort_q;
  assign rd_data         = rd_q;
  assign query_ok        = qok_q;
  assign ext_table_addr  = ext_q;
  assign vcc_min         = vmin_q;
  assign vcc_max         = vmax_q;
  assign blk_protected   = prot_q;
  assign blk_checked     = chk_q;
  assign unprotect_ready = upr_q;
  assign fl_ce_n         = ce_n_q;
  assign fl_oe_n         = oe_n_q;
  assign fl_we_n         = we_n_q;
  assign fl_addr         = fa_q;
  assign fl_dq_o         = fdo_q;
  assign fl_dq_oe        = foe_q;
  assign fl_reset_n      = rst_n_q;
  assign fl_reset_hv     = hv_q;
endmodule // fpq_host

// file: rtl/fpq_qmem.sv
// Small memory holding the captured query bytes, registered read port
`timescale 1ns/10ps
module fpq_qmem
  import fpq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [4:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [4:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [0:31];

  always_ff @(posedge clk) begin
    if (we && waddr < QMEM_WORDS) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // fpq_qmem

// file: shared/fpq_pkg.sv
// Constants, types and step decoding for the flash protect and query host controller
package fpq_pkg;
  localparam int          CLK_NS       = 40;
  localparam int          T_ACC_NS     = 70;
  localparam int          T_WP_NS      = 35;
  localparam int          T_PWRUP_NS   = 1000;
  localparam logic [4:0]  ACC_CYC      = 5'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0]  WP_CYC       = 5'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  PWRUP_CYC    = 8'((T_PWRUP_NS + CLK_NS - 1) / CLK_NS);
  localparam int          NUM_BLOCKS   = 18;
  // Operations on the user command port
  localparam logic [2:0]  OP_READ      = 3'h0;
  localparam logic [2:0]  OP_PROG      = 3'h1;
  localparam logic [2:0]  OP_QUERY     = 3'h2;
  localparam logic [2:0]  OP_PCHK      = 3'h3;
  localparam logic [2:0]  OP_RESET     = 3'h4;
  // Command bytes and addresses
  localparam logic [21:0] A_UNLOCK1    = 22'h00_0555;
  localparam logic [21:0] A_UNLOCK2    = 22'h00_02AA;
  localparam logic [21:0] A_QUERY      = 22'h00_0055;
  localparam logic [15:0] A_PROT_OFS   = 16'h0002;
  localparam logic [7:0]  D_UNLOCK1    = 8'hAA;
  localparam logic [7:0]  D_UNLOCK2    = 8'h55;
  localparam logic [7:0]  D_PROG       = 8'hA0;
  localparam logic [7:0]  D_AUTOSEL    = 8'h90;
  localparam logic [7:0]  D_QUERY      = 8'h98;
  localparam logic [7:0]  D_RESET      = 8'hF0;
  localparam logic [7:0]  D_PROTECTED  = 8'h01;
  // Query table layout
  localparam logic [5:0]  Q_FIRST      = 6'h10;
  localparam logic [5:0]  Q_EXT_LO     = 6'h15;
  localparam logic [5:0]  Q_EXT_HI     = 6'h16;
  localparam logic [5:0]  Q_VMIN       = 6'h1B;
  localparam logic [5:0]  Q_VMAX       = 6'h1C;
  localparam logic [4:0]  Q_LAST_STEP  = 5'd23;
  localparam logic [7:0]  Q_SIG0       = 8'h51;
  localparam logic [7:0]  Q_SIG1       = 8'h52;
  localparam logic [7:0]  Q_SIG2       = 8'h59;
  localparam logic [4:0]  QMEM_WORDS   = 5'd23;

  typedef enum logic [1:0] {
    FPQ_CY_IDLE = 2'b00, FPQ_CY_SETUP = 2'b01, FPQ_CY_STROBE = 2'b11, FPQ_CY_HOLD = 2'b10
  } fpq_cycle_t;

  typedef struct packed {
    logic        wr;
    logic [21:0] a;
    logic [7:0]  d;
  } fpq_step_t;

  // Bus cycle for step idx of an operation
  function automatic fpq_step_t fpq_step(input logic [2:0] op, input logic [4:0] idx,
                                         input logic [21:0] ua, input logic [7:0] ud);
    fpq_step_t s;
    s = '{wr: 1'b1, a: 22'h00_0000, d: D_RESET};
    if (op == OP_READ) begin
      s = '{wr: 1'b0, a: ua, d: 8'h00};
    end else if ((op == OP_PROG || op == OP_PCHK) && idx < 5'd3) begin
      case (idx)
        5'd0:    s = '{wr: 1'b1, a: A_UNLOCK1, d: D_UNLOCK1};
        5'd1:    s = '{wr: 1'b1, a: A_UNLOCK2, d: D_UNLOCK2};
        default: s = '{wr: 1'b1, a: A_UNLOCK1, d: (op == OP_PROG) ? D_PROG : D_AUTOSEL};
      endcase
    end else if (op == OP_PROG) begin
      s = '{wr: 1'b1, a: ua, d: ud};
    end else if (op == OP_PCHK && idx == 5'd3) begin
      s = '{wr: 1'b0, a: {ua[21:16], A_PROT_OFS}, d: 8'h00};
    end else if (op == OP_QUERY && idx == 5'd0) begin
      s = '{wr: 1'b1, a: A_QUERY, d: D_QUERY};
    end else if (op == OP_QUERY && idx <= Q_LAST_STEP) begin
      s = '{wr: 1'b0, a: {16'h0000, Q_FIRST + {1'b0, idx} - 6'd1}, d: 8'h00};
    end
    return s;
  endfunction

  function automatic logic [4:0] fpq_last(input logic [2:0] op);
    case (op)
      OP_PROG:  return 5'd3;
      OP_QUERY: return Q_LAST_STEP + 5'd1;
      OP_PCHK:  return 5'd4;
      default:  return 5'd0;
    endcase
  endfunction

  // Sector block index from the top six address lines
  function automatic logic [4:0] fpq_block(input logic [5:0] sa);
    if (sa == 6'd0)       return 5'd0;
    else if (sa <= 6'd3)  return 5'd1;
    else if (sa <= 6'd59) return 5'({1'b0, sa[5:2]} + 5'd1);
    else if (sa <= 6'd62) return 5'd16;
    else                  return 5'd17;
  endfunction
endpackage
